// *** rtl/wwd_regs.svh ***
// constants for the windowed watchdog: timing counts and bit positions
`ifndef WWD_REGS_SVH
`define WWD_REGS_SVH

// system clock and watchdog oscillator rates
`define WWD_CLK_KHZ          200000
`define WWD_OSC_KHZ          31
// system clocks per oscillator period, rounded down
`define WWD_OSC_DIV_CYC      (`WWD_CLK_KHZ / `WWD_OSC_KHZ)

// prescaler widths: 5-bit divides by 32, 7-bit by 128
`define WWD_PRE5_BITS        5
`define WWD_PRE7_BITS        7
// nominal base time-out per prescaler mode, in microseconds
`define WWD_BASE_TIMEOUT_5_US 1000
`define WWD_BASE_TIMEOUT_7_US 4000

// config word one fields
`define WWD_CFG1_POSTSCALE_LSB 0
`define WWD_CFG1_POSTSCALE_MSB 3
`define WWD_CFG1_WINDOW_DIS    6

// reset control register bits
`define WWD_RSTCTL_IDLE        2
`define WWD_RSTCTL_SLEEP       3
`define WWD_RSTCTL_TIMEOUT     4
`define WWD_RSTCTL_SW_ENABLE   5
`define WWD_RSTCTL_RESET_VAL   8'h00

// combined prescaler and postscaler counter width
`define WWD_CNT_W             22

`endif

// *** rtl/wwd_pkg.sv ***
// types for the windowed watchdog
package wwd_pkg;

  typedef enum logic [1:0] {PWR_RUN, PWR_SLEEP, PWR_IDLE} wwd_pwr_t;

  typedef struct packed {
    logic [21:0] cnt;
    wwd_pwr_t    pwr;
    logic        sw_en;
    logic        to_flag;
    logic        slp_flag;
    logic        idl_flag;
    logic        rst_pulse;
    logic        wake_pulse;
    logic        osc_en;
    logic        in_ps;
  } wwd_state_t;

  typedef struct packed {
    logic [12:0] div;
    logic        tick;
  } wwd_osc_state_t;

endpackage : wwd_pkg

// *** rtl/wwd_osc_tick.sv ***
// low power rc oscillator stand-in: one tick per oscillator period
`timescale 1ns/10ps
`include "wwd_regs.svh"
module wwd_osc_tick
  import wwd_pkg::*;
#(
  parameter int OSC_DIV = `WWD_OSC_DIV_CYC
) (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_enable,
  output logic      o_tick
);

  wwd_osc_state_t st_reg;
  wwd_osc_state_t st_next;

  always_comb begin
    st_next      = st_reg;
    st_next.tick = 1'b0;
    // stopped oscillator restarts a full period later
    if (!i_enable) begin
      st_next.div = 13'h0000;
    end else if (st_reg.div == 13'(OSC_DIV - 1)) begin
      st_next.div  = 13'h0000;
      st_next.tick = 1'b1;
    end else begin
      st_next.div = st_reg.div + 13'h0001;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_tick = st_reg.tick;

endmodule : wwd_osc_tick

// *** rtl/wwd_core.sv ***
// windowed watchdog timer core with power-save wake and reset control bits
`timescale 1ns/10ps
`include "wwd_regs.svh"
module wwd_core
  import wwd_pkg::*;
#(
  parameter int OSC_DIV = `WWD_OSC_DIV_CYC
) (
  input  wire logic        I_CLK,
  input  wire logic        I_SYS_RST,
  input  wire logic        I_DEVICE_RESET,
  input  wire logic        I_HW_ENABLE_CFG,
  input  wire logic        I_PRESCALE_SELECT_CFG,
  input  wire logic [15:0] I_CONFIG_WORD_ONE,
  input  wire logic        I_WATCHDOG_CLEAR_INSTR,
  input  wire logic        I_POWER_SAVE_INSTR,
  input  wire logic        I_POWER_SAVE_IDLE,
  input  wire logic        I_WAKE_EVENT,
  input  wire logic        I_CLOCK_SWITCH_DONE,
  input  wire logic        I_RESET_CONTROL_WR,
  input  wire logic [7:0]  I_RESET_CONTROL_WDATA,
  output logic             O_LOW_POWER_RC_OSC_EN,
  output logic             O_WATCHDOG_RESET,
  output logic             O_WATCHDOG_WAKE,
  output logic             O_TIMEOUT_FLAG,
  output logic             O_SW_ENABLE_BIT,
  output logic [7:0]       O_RESET_CONTROL_REG,
  output logic             O_IN_POWER_SAVE
);

  wwd_state_t st_reg;
  wwd_state_t st_next;

  logic       osc_tick;
  logic       wd_en;
  logic [7:0] rst_ctl_word;
  logic       window_mode;
  logic       cnt_clr;
  logic [3:0] post_sel;
  logic [22:0] period;
  logic [22:0] win_start;

  // full period in oscillator ticks: prescale times postscale ratio
  function automatic logic [22:0] period_len(input logic sel7, input logic [3:0] ps);
    logic [4:0] sh;
    sh = sel7 ? 5'(`WWD_PRE7_BITS) : 5'(`WWD_PRE5_BITS);
    period_len = 23'h000001 << (sh + 5'(ps));
  endfunction : period_len

  wwd_osc_tick #(
    .OSC_DIV (OSC_DIV)
  ) u_osc (
    .i_clk    (I_CLK),
    .i_rst    (I_SYS_RST),
    .i_enable (st_reg.osc_en),
    .o_tick   (osc_tick)
  );

  assign post_sel    = I_CONFIG_WORD_ONE[`WWD_CFG1_POSTSCALE_MSB:`WWD_CFG1_POSTSCALE_LSB];
  assign window_mode = ~I_CONFIG_WORD_ONE[`WWD_CFG1_WINDOW_DIS];
  assign wd_en       = I_HW_ENABLE_CFG | st_reg.sw_en;
  assign period      = period_len(I_PRESCALE_SELECT_CFG, post_sel);
  // last quarter starts at three quarters of the period
  assign win_start   = period - (period >> 2);

  always_comb begin
    st_next            = st_reg;
    st_next.rst_pulse  = 1'b0;
    st_next.wake_pulse = 1'b0;
    st_next.osc_en     = wd_en;
    cnt_clr            = 1'b0;
    if (I_DEVICE_RESET) begin
      // flags survive so software can see why it restarted
      st_next.cnt   = '0;
      st_next.sw_en = 1'b0;
      st_next.pwr   = PWR_RUN;
    end else begin
      if (I_RESET_CONTROL_WR) begin
        st_next.sw_en    = I_RESET_CONTROL_WDATA[`WWD_RSTCTL_SW_ENABLE];
        st_next.to_flag  = I_RESET_CONTROL_WDATA[`WWD_RSTCTL_TIMEOUT];
        st_next.slp_flag = I_RESET_CONTROL_WDATA[`WWD_RSTCTL_SLEEP];
        st_next.idl_flag = I_RESET_CONTROL_WDATA[`WWD_RSTCTL_IDLE];
      end
      if (I_CLOCK_SWITCH_DONE) begin
        cnt_clr = 1'b1;
      end
      unique case (st_reg.pwr)
        PWR_RUN: begin
          if (I_POWER_SAVE_INSTR) begin
            cnt_clr = 1'b1;
            if (I_POWER_SAVE_IDLE) begin
              st_next.pwr      = PWR_IDLE;
              st_next.idl_flag = 1'b1;
            end else begin
              st_next.pwr      = PWR_SLEEP;
              st_next.slp_flag = 1'b1;
            end
          end else if (I_WATCHDOG_CLEAR_INSTR) begin
            cnt_clr = 1'b1;
            // early clear only counts while the watchdog actually runs
            if (wd_en && window_mode && (23'(st_reg.cnt) < win_start)) begin
              st_next.rst_pulse = 1'b1;
              st_next.to_flag   = 1'b1;
            end
          end
        end
        PWR_SLEEP, PWR_IDLE: begin
          if (I_WAKE_EVENT) begin
            st_next.pwr = PWR_RUN;
            cnt_clr     = 1'b1;
          end
        end
        // unused code: fall back to run rather than lock up
        default: begin
          st_next.pwr = PWR_RUN;
        end
      endcase
      if (!wd_en || cnt_clr) begin
        st_next.cnt = '0;
      end else if (osc_tick) begin
        if (23'(st_reg.cnt) == period - 23'h000001) begin
          st_next.cnt     = '0;
          st_next.to_flag = 1'b1;
          if (st_reg.pwr == PWR_RUN) begin
            st_next.rst_pulse = 1'b1;
          end else begin
            st_next.wake_pulse = 1'b1;
            st_next.pwr        = PWR_RUN;
          end
        end else begin
          st_next.cnt = st_reg.cnt + 22'h000001;
        end
      end
    end
    // registered so the power-save output needs no decode gate
    st_next.in_ps = (st_next.pwr != PWR_RUN);
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign O_LOW_POWER_RC_OSC_EN = st_reg.osc_en;
  assign O_WATCHDOG_RESET      = st_reg.rst_pulse;
  assign O_WATCHDOG_WAKE       = st_reg.wake_pulse;
  assign O_TIMEOUT_FLAG        = st_reg.to_flag;
  assign O_SW_ENABLE_BIT       = st_reg.sw_en;
  assign O_IN_POWER_SAVE       = st_reg.in_ps;

  // pure wiring of flag flops into their bit positions
  always_comb begin
    rst_ctl_word                          = `WWD_RSTCTL_RESET_VAL;
    rst_ctl_word[`WWD_RSTCTL_SW_ENABLE]   = st_reg.sw_en;
    rst_ctl_word[`WWD_RSTCTL_TIMEOUT]     = st_reg.to_flag;
    rst_ctl_word[`WWD_RSTCTL_SLEEP]       = st_reg.slp_flag;
    rst_ctl_word[`WWD_RSTCTL_IDLE]        = st_reg.idl_flag;
  end

  assign O_RESET_CONTROL_REG   = rst_ctl_word;

endmodule : wwd_core

// *** verif/wwd_core_chk.sv ***
// port-level checker for the windowed watchdog core
`timescale 1ns/10ps
module wwd_core_chk (
  input wire logic       I_CLK,
  input wire logic       I_SYS_RST,
  input wire logic       I_DEVICE_RESET,
  input wire logic       I_HW_ENABLE_CFG,
  input wire logic       I_POWER_SAVE_INSTR,
  input wire logic       I_POWER_SAVE_IDLE,
  input wire logic       I_RESET_CONTROL_WR,
  input wire logic [7:0] I_RESET_CONTROL_WDATA,
  input wire logic       O_LOW_POWER_RC_OSC_EN,
  input wire logic       O_WATCHDOG_RESET,
  input wire logic       O_WATCHDOG_WAKE,
  input wire logic       O_TIMEOUT_FLAG,
  input wire logic       O_SW_ENABLE_BIT,
  input wire logic [7:0] O_RESET_CONTROL_REG,
  input wire logic       O_IN_POWER_SAVE
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);
  a_osc_follows_en: assert property (!$past(I_SYS_RST) && !$past(I_DEVICE_RESET) |->
    O_LOW_POWER_RC_OSC_EN == $past(I_HW_ENABLE_CFG || O_SW_ENABLE_BIT)) else $error("osc enable wrong");
  a_dev_rst_sw: assert property (I_DEVICE_RESET |=> !O_SW_ENABLE_BIT && $stable(O_TIMEOUT_FLAG))
    else $error("device reset left sw enable");
  a_rst_sets_flag: assert property (O_WATCHDOG_RESET |-> O_TIMEOUT_FLAG ##1 !O_WATCHDOG_RESET)
    else $error("reset pulse without flag");
  a_wake_sets_flag: assert property (O_WATCHDOG_WAKE |-> O_TIMEOUT_FLAG && !O_WATCHDOG_RESET)
    else $error("wake pulse wrong");
  a_wake_exits_ps: assert property (O_WATCHDOG_WAKE |-> !O_IN_POWER_SAVE)
    else $error("still in power save after wake");
  a_flag_sw_clear: assert property ($fell(O_TIMEOUT_FLAG) |-> $past(I_RESET_CONTROL_WR))
    else $error("flag cleared by hardware");
  a_ps_entry: assert property (I_POWER_SAVE_INSTR && !O_IN_POWER_SAVE && !I_DEVICE_RESET |=>
    O_IN_POWER_SAVE && O_RESET_CONTROL_REG[$past(I_POWER_SAVE_IDLE) ? 2 : 3]) else $error("power save entry");
  a_reg_map: assert property (O_RESET_CONTROL_REG[7:4] == {2'h0, O_SW_ENABLE_BIT, O_TIMEOUT_FLAG}
    && O_RESET_CONTROL_REG[1:0] == 2'h0) else $error("reset control map wrong");
  a_wr_sw_en: assert property (I_RESET_CONTROL_WR && !I_DEVICE_RESET |=>
    O_SW_ENABLE_BIT == $past(I_RESET_CONTROL_WDATA[5])) else $error("sw enable write lost");
endmodule : wwd_core_chk
bind wwd_core wwd_core_chk u_chk (
  .I_CLK                 (I_CLK),
  .I_SYS_RST             (I_SYS_RST),
  .I_DEVICE_RESET        (I_DEVICE_RESET),
  .I_HW_ENABLE_CFG       (I_HW_ENABLE_CFG),
  .I_POWER_SAVE_INSTR    (I_POWER_SAVE_INSTR),
  .I_POWER_SAVE_IDLE     (I_POWER_SAVE_IDLE),
  .I_RESET_CONTROL_WR    (I_RESET_CONTROL_WR),
  .I_RESET_CONTROL_WDATA (I_RESET_CONTROL_WDATA),
  .O_LOW_POWER_RC_OSC_EN (O_LOW_POWER_RC_OSC_EN),
  .O_WATCHDOG_RESET      (O_WATCHDOG_RESET),
  .O_WATCHDOG_WAKE       (O_WATCHDOG_WAKE),
  .O_TIMEOUT_FLAG        (O_TIMEOUT_FLAG),
  .O_SW_ENABLE_BIT       (O_SW_ENABLE_BIT),
  .O_RESET_CONTROL_REG   (O_RESET_CONTROL_REG),
  .O_IN_POWER_SAVE       (O_IN_POWER_SAVE)
);

// *** verif/wwd_core_tb.sv ***
// self-checking bench for the windowed watchdog core
`timescale 1ns/10ps
module wwd_core_tb;
  localparam int D = 4;
  logic I_CLK = 1'h0, I_SYS_RST = 1'h1, I_DEVICE_RESET = 1'h0, I_HW_ENABLE_CFG = 1'h1;
  logic I_PRESCALE_SELECT_CFG = 1'h0, I_WATCHDOG_CLEAR_INSTR = 1'h0, I_POWER_SAVE_INSTR = 1'h0;
  logic I_POWER_SAVE_IDLE = 1'h0, I_WAKE_EVENT = 1'h0, I_CLOCK_SWITCH_DONE = 1'h0, I_RESET_CONTROL_WR = 1'h0;
  logic [15:0] I_CONFIG_WORD_ONE = 16'h0040;
  logic [7:0]  I_RESET_CONTROL_WDATA = 8'h00, O_RESET_CONTROL_REG;
  logic        O_LOW_POWER_RC_OSC_EN, O_WATCHDOG_RESET, O_WATCHDOG_WAKE, O_TIMEOUT_FLAG, O_SW_ENABLE_BIT;
  logic        O_IN_POWER_SAVE;
  int          errors = 0, cmp_count = 0, n;
  // {select, postscale, period in clocks}; long ratios skipped to bound run time
  logic [23:0] rows [5] = '{24'h000080, 24'h100200, 24'h010100, 24'h020200, 24'h110400};
  wwd_core #(.OSC_DIV(D)) dut (
    .I_CLK                  (I_CLK),
    .I_SYS_RST              (I_SYS_RST),
    .I_DEVICE_RESET         (I_DEVICE_RESET),
    .I_HW_ENABLE_CFG        (I_HW_ENABLE_CFG),
    .I_PRESCALE_SELECT_CFG  (I_PRESCALE_SELECT_CFG),
    .I_CONFIG_WORD_ONE      (I_CONFIG_WORD_ONE),
    .I_WATCHDOG_CLEAR_INSTR (I_WATCHDOG_CLEAR_INSTR),
    .I_POWER_SAVE_INSTR     (I_POWER_SAVE_INSTR),
    .I_POWER_SAVE_IDLE      (I_POWER_SAVE_IDLE),
    .I_WAKE_EVENT           (I_WAKE_EVENT),
    .I_CLOCK_SWITCH_DONE    (I_CLOCK_SWITCH_DONE),
    .I_RESET_CONTROL_WR     (I_RESET_CONTROL_WR),
    .I_RESET_CONTROL_WDATA  (I_RESET_CONTROL_WDATA),
    .O_LOW_POWER_RC_OSC_EN  (O_LOW_POWER_RC_OSC_EN),
    .O_WATCHDOG_RESET       (O_WATCHDOG_RESET),
    .O_WATCHDOG_WAKE        (O_WATCHDOG_WAKE),
    .O_TIMEOUT_FLAG         (O_TIMEOUT_FLAG),
    .O_SW_ENABLE_BIT        (O_SW_ENABLE_BIT),
    .O_RESET_CONTROL_REG    (O_RESET_CONTROL_REG),
    .O_IN_POWER_SAVE        (O_IN_POWER_SAVE)
  );
  always #2.5 I_CLK = ~I_CLK;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(posedge I_CLK);
    #1;
  endtask : cyc
  task automatic pulse(ref logic s);
    s = 1'h1;
    cyc(1);
    s = 1'h0;
  endtask : pulse
  task automatic restart(input logic [7:0] cw);
    I_SYS_RST = 1'h1;
    I_CONFIG_WORD_ONE = {8'h00, cw};
    cyc(2);
    I_SYS_RST = 1'h0;
  endtask : restart
  task automatic wr(input logic [7:0] d);
    I_RESET_CONTROL_WDATA = d;
    pulse(I_RESET_CONTROL_WR);
    cyc(1);
  endtask : wr
  // bounded wait so a dead counter cannot hang the run
  task automatic wait_ev();
    for (n = 0; !(O_WATCHDOG_RESET || O_WATCHDOG_WAKE) && n < 5000; n++) cyc(1);
    if (n == 5000) errors++;
  endtask : wait_ev
  task automatic finish_test();
    if (errors == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test
  initial begin
    #100000;
    errors++;
    finish_test();
  end
  initial begin
    cyc(12);
    chk({O_RESET_CONTROL_REG, O_WATCHDOG_RESET}, 9'h000);
    foreach (rows[i]) begin
      I_PRESCALE_SELECT_CFG = rows[i][20];
      restart({4'h4, rows[i][19:16]});
      wait_ev();
      chk(n >= rows[i][15:0] - 1 && n <= rows[i][15:0] + D + 2, 1);
      chk({O_WATCHDOG_RESET, O_TIMEOUT_FLAG}, 2'h3);
      cyc(3);
      chk(O_TIMEOUT_FLAG, 1'h1);
      wr(8'h00);
      chk(O_TIMEOUT_FLAG, 1'h0);
    end
    I_PRESCALE_SELECT_CFG = 1'h0;
    I_HW_ENABLE_CFG = 1'h0;
    restart(8'h40);
    cyc(3);
    chk(O_LOW_POWER_RC_OSC_EN, 1'h0);
    wr(8'h20);
    chk({O_SW_ENABLE_BIT, O_LOW_POWER_RC_OSC_EN, O_RESET_CONTROL_REG}, 10'h320);
    wait_ev();
    chk({O_WATCHDOG_RESET, O_TIMEOUT_FLAG}, 2'h3);
    pulse(I_DEVICE_RESET);
    chk({O_SW_ENABLE_BIT, O_TIMEOUT_FLAG}, 2'h1);
    I_HW_ENABLE_CFG = 1'h1;
    restart(8'h00);
    cyc(20);
    pulse(I_WATCHDOG_CLEAR_INSTR);
    chk(O_WATCHDOG_RESET, 1'h1);
    restart(8'h00);
    cyc(108);
    pulse(I_WATCHDOG_CLEAR_INSTR);
    chk(O_WATCHDOG_RESET, 1'h0);
    wait_ev();
    chk(n inside {[124:134]}, 1);
    restart(8'h40);
    cyc(60);
    pulse(I_CLOCK_SWITCH_DONE);
    wait_ev();
    chk(n inside {[124:134]}, 1);
    for (int k = 0; k < 2; k++) begin
      restart(8'h40);
      cyc(60);
      I_POWER_SAVE_IDLE = k[0];
      pulse(I_POWER_SAVE_INSTR);
      chk({O_IN_POWER_SAVE, O_RESET_CONTROL_REG[3:2]}, k ? 3'h5 : 3'h6);
      if (k) begin
        cyc(60);
        pulse(I_WAKE_EVENT);
      end
      wait_ev();
      chk(n inside {[124:134]}, 1);
      chk({O_WATCHDOG_WAKE, O_WATCHDOG_RESET}, k ? 2'h1 : 2'h2);
      wr(8'h00);
      chk(O_RESET_CONTROL_REG, 8'h00);
    end
    finish_test();
  end
endmodule : wwd_core_tb
